// ==== master_status_reply_builder.sv ====
// Master status reply builder: flags, control state, error record and reply streamer
// Functional notes
// - First reply word echoes the status command code 0x0002.
// - Word 2 flags, word 3 state code, word 4 low address, high event.
// - Words 5 to 9 reserved; requester must offer at least nine words.
// - With no error reported, every flag bit reads zero.
// - Bit 0 parameterization error; bit 1 auto-clear end state reached.
// - Bit 2 some slave not exchanging; bit 3 fatal network fault.
// - Bit 4 set by first short circuit; each one counts until the counter saturates, header word 6.
// - Bit 5 shows the host program not yet ready.
// - Bit 6 set by first telegram timeout; each one counts until the counter saturates, header word 7.
// - State code is 0x00 idle, 0x40 halted, 0x80 clearing, 0xC0 operating.
// - Halted loads bus parameters, initializes diagnostics, moves no data.
// - Clearing configures slaves, reads inputs, holds outputs back.
// - Operating sends outputs cyclically and reads inputs every cycle.
// - Master-sourced error puts 255 in the address byte.
// - Station error puts its address 0 to 125 and its code.
// - Event byte holds the code of the device in the address byte.
// - Header word 4 mirrors flags low byte, state code high byte.
// - Header word 5 high byte mirrors the error event code.
`timescale 1ns/10ps
`default_nettype none
`include "status_reply_map.svh"

module master_status_reply_builder
	import status_reply_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RESET_N,
	input  wire logic        PARAM_ERROR,
	input  wire logic        AUTO_CLEAR_END,
	input  wire logic        NO_EXCHANGE,
	input  wire logic        FATAL_NET,
	input  wire logic        SHORT_EVENT,
	input  wire logic        HOST_UNREADY,
	input  wire logic        TIMEOUT_EVENT,
	input  wire logic        CLEAR_ERRORS,
	input  wire logic        ERR_VALID,
	input  wire logic        ERR_FROM_MASTER,
	input  wire logic [7:0]  ERR_STATION,
	input  wire logic [7:0]  ERR_CODE,
	input  wire logic        STATE_GO,
	input  wire logic [1:0]  STATE_TARGET,
	input  wire logic        STAT_REQ,
	input  wire logic        STAT_HEADER,
	input  wire logic [15:0] STAT_CMD,
	input  wire logic [15:0] STAT_SIZE,
	output logic             STAT_BUSY,
	output logic             REPLY_VALID,
	output logic [3:0]       REPLY_NUM,
	output logic [15:0]      REPLY_DATA,
	output logic             REPLY_REFUSED,
	output logic [7:0]       CONTROL_STATE_CODE,
	output logic             LOAD_BUS_PARAMS,
	output logic             INIT_DIAG,
	output logic             CONFIG_SLAVES,
	output logic             READ_INPUTS,
	output logic             HOLD_OUTPUTS,
	output logic             SEND_OUTPUTS
);

	// Counters are reported in one reply word, so they may not exceed it
	if (CNT_W < 1 || CNT_W > 16) begin : g_cnt_w_bad
		$error("CNT_W must lie between 1 and 16");
	end

	////////////////////////////////////////////////////////////////////////
	// Global state flags

	flags_type              flags_r;
	flags_type              flags_nxt;
	logic                   short_seen_r;
	logic                   short_seen_nxt;
	logic                   timeout_seen_r;
	logic                   timeout_seen_nxt;
	logic [CNT_W-1:0]       bus_err_cnt_r;
	logic [CNT_W-1:0]       bus_err_cnt_nxt;
	logic [CNT_W-1:0]       timeout_cnt_r;
	logic [CNT_W-1:0]       timeout_cnt_nxt;
	wire logic              bus_err_full;
	wire logic              timeout_full;

	// Sticky bits: an event in the clearing cycle still sets, set wins
	assign short_seen_nxt = SHORT_EVENT | (short_seen_r & ~CLEAR_ERRORS);
	assign timeout_seen_nxt = TIMEOUT_EVENT | (timeout_seen_r & ~CLEAR_ERRORS);

	// Counters saturate rather than wrap, so a large count never reads small
	assign bus_err_full    = &bus_err_cnt_r;
	assign timeout_full    = &timeout_cnt_r;
	assign bus_err_cnt_nxt = SHORT_EVENT && !bus_err_full ? bus_err_cnt_r + 1'b1 : bus_err_cnt_r;
	assign timeout_cnt_nxt = TIMEOUT_EVENT && !timeout_full ? timeout_cnt_r + 1'b1 : timeout_cnt_r;

	// Level flags follow their sources one cycle late; bit 7 stays zero
	always_comb begin
		flags_nxt                       = flags_type'(`FLAGS_RESET);
		flags_nxt.param_error_flag      = PARAM_ERROR;
		flags_nxt.auto_clear_flag       = AUTO_CLEAR_END;
		flags_nxt.no_exchange_flag      = NO_EXCHANGE;
		flags_nxt.fatal_net_flag        = FATAL_NET;
		flags_nxt.short_circuit_flag    = short_seen_nxt;
		flags_nxt.host_unready_flag     = HOST_UNREADY;
		flags_nxt.telegram_timeout_flag = timeout_seen_nxt;
		flags_nxt.reserved7             = 1'b0;
	end

	// Flag and counter registers
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			flags_r       <= flags_type'(`FLAGS_RESET);
			short_seen_r  <= 1'b0;
			timeout_seen_r <= 1'b0;
			bus_err_cnt_r  <= '0;
			timeout_cnt_r  <= '0;
		end else begin
			flags_r       <= flags_nxt;
			short_seen_r  <= short_seen_nxt;
			timeout_seen_r <= timeout_seen_nxt;
			bus_err_cnt_r  <= bus_err_cnt_nxt;
			timeout_cnt_r  <= timeout_cnt_nxt;
		end
	end

	chk_short_first_sets: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		SHORT_EVENT |=> flags_r.short_circuit_flag)
		else $error("short circuit event did not set flag bit 4");

	chk_short_counts: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		SHORT_EVENT && !bus_err_full |=> bus_err_cnt_r == $past(bus_err_cnt_r) + 1'b1)
		else $error("bus error counter missed a short circuit");

	chk_timeout_counts: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		TIMEOUT_EVENT && !timeout_full |=> timeout_cnt_r == $past(timeout_cnt_r) + 1'b1
		&& flags_r.telegram_timeout_flag)
		else $error("timeout not counted or flag bit 6 not set");

	chk_no_error_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		!(PARAM_ERROR | AUTO_CLEAR_END | NO_EXCHANGE | FATAL_NET | HOST_UNREADY)
		&& CLEAR_ERRORS && !SHORT_EVENT && !TIMEOUT_EVENT |=> flags_r == `FLAGS_RESET)
		else $error("flag word not zero with no error present");

	chk_flag_follow: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		##1 flags_r.param_error_flag == $past(PARAM_ERROR) && flags_r.fatal_net_flag == $past(FATAL_NET)
		&& flags_r.host_unready_flag == $past(HOST_UNREADY) && !flags_r.reserved7)
		else $error("level flag does not follow its source");

	////////////////////////////////////////////////////////////////////////
	// Error record: address of the failing device and its event code

	logic [7:0]             err_addr_r;
	logic [7:0]             err_addr_nxt;
	logic [7:0]             err_event_r;
	logic [7:0]             err_event_nxt;
	wire logic              station_ok;
	wire logic              err_take;

	// Station reports beyond the legal address range are dropped
	assign station_ok = ERR_STATION <= `MAX_STATION_ADDR;
	assign err_take   = ERR_VALID && (ERR_FROM_MASTER || station_ok);

	// A new report wins over a clear in the same cycle
	assign err_addr_nxt  = !err_take ? (CLEAR_ERRORS ? `NO_ERROR_ADDR : err_addr_r) :
		ERR_FROM_MASTER ? `MASTER_SOURCE_ADDR : ERR_STATION;
	assign err_event_nxt = err_take ? ERR_CODE :
		(CLEAR_ERRORS ? `NO_ERROR_EVENT : err_event_r);

	// Address and event always load together so they never disagree
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			err_addr_r  <= `NO_ERROR_ADDR;
			err_event_r <= `NO_ERROR_EVENT;
		end else begin
			err_addr_r  <= err_addr_nxt;
			err_event_r <= err_event_nxt;
		end
	end

	chk_master_addr: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		ERR_VALID && ERR_FROM_MASTER |=> err_addr_r == `MASTER_SOURCE_ADDR && err_event_r == $past(ERR_CODE))
		else $error("master error did not record address 255");

	chk_station_addr: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		ERR_VALID && !ERR_FROM_MASTER && station_ok |=> err_addr_r == $past(ERR_STATION)
		&& err_event_r == $past(ERR_CODE))
		else $error("station error not recorded with its code");

	chk_addr_range: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		err_addr_r <= `MAX_STATION_ADDR || err_addr_r == `MASTER_SOURCE_ADDR)
		else $error("error address outside station range and not 255");

	////////////////////////////////////////////////////////////////////////
	// Control state machine

	ctrl_state_type         state_r;
	ctrl_state_type         state_nxt;
	ctrl_state_type         target;
	logic                   init_diag_r;

	// Requested target, decoded from the two-bit selector
	assign target = STATE_TARGET == 2'h0 ? IDLE_STATE :
		STATE_TARGET == 2'h1 ? HALTED :
		STATE_TARGET == 2'h2 ? CLEARING : OPERATING;

	// A fatal fault forces halt unless the next state is idle; auto-clear end drops operation to clearing
	always_comb begin
		state_nxt = state_r;
		if (STATE_GO) begin
			state_nxt = target;
		end
		unique case (state_r)
			OPERATING: begin
				if (AUTO_CLEAR_END) begin
					state_nxt = CLEARING;
				end
			end
			IDLE_STATE, HALTED, CLEARING: begin
			end
		endcase
		if (FATAL_NET && state_nxt != IDLE_STATE) begin
			state_nxt = HALTED;
		end
	end

	// State register and one-cycle diagnostic init on entry to halt
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r     <= IDLE_STATE;
			init_diag_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			init_diag_r <= state_nxt == HALTED && state_r != HALTED;
		end
	end

	// Phase outputs decode the state register directly, except INIT_DIAG, which comes from init_diag_r
	assign CONTROL_STATE_CODE = state_r;
	assign LOAD_BUS_PARAMS    = state_r == HALTED;
	assign INIT_DIAG          = init_diag_r;
	assign CONFIG_SLAVES      = state_r == CLEARING;
	assign READ_INPUTS        = state_r == CLEARING || state_r == OPERATING;
	assign HOLD_OUTPUTS       = state_r == CLEARING;
	assign SEND_OUTPUTS       = state_r == OPERATING;

	sequence enter_halt_seq;
		state_r != HALTED ##1 state_r == HALTED;
	endsequence

	chk_halt_entry: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		enter_halt_seq |-> INIT_DIAG && LOAD_BUS_PARAMS && !SEND_OUTPUTS && !READ_INPUTS)
		else $error("halt entry without parameter load and diagnostic init");

	chk_no_send_clear: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		state_r == CLEARING |-> HOLD_OUTPUTS && READ_INPUTS && !SEND_OUTPUTS)
		else $error("clearing state sends outputs");

	chk_state_codes: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		STATE_GO && !FATAL_NET && !AUTO_CLEAR_END |=> CONTROL_STATE_CODE == {$past(STATE_TARGET), 6'h00})
		else $error("state code does not match requested state");

	////////////////////////////////////////////////////////////////////////
	// Reply streamer

	snapshot_type           live;
	snapshot_type           snap_r;
	logic                   busy_r;
	logic                   hdr_r;
	logic [3:0]             idx_r;
	logic                   out_valid_r;
	logic [3:0]             out_num_r;
	logic [15:0]            out_data_r;
	logic                   refused_r;
	logic [15:0]            word_nxt;
	wire logic              size_ok;
	wire logic              cmd_ok;
	wire logic              req_take;
	wire logic              req_bad;

	// Counters widen to a full reply word
	always_comb begin
		live            = '0;
		live.flags      = flags_r;
		live.state_code = state_r;
		live.err_addr   = err_addr_r;
		live.err_event  = err_event_r;
		live.bus_errors = 16'(bus_err_cnt_r);
		live.timeouts   = 16'(timeout_cnt_r);
	end

	// Too small an answer area is refused whole, never truncated
	assign size_ok  = STAT_SIZE >= `REPLY_MIN_WORDS;
	assign cmd_ok   = STAT_HEADER || STAT_CMD == `STATUS_CMD_CODE;
	assign req_take = STAT_REQ && !busy_r && size_ok && cmd_ok;
	assign req_bad  = STAT_REQ && !busy_r && !(size_ok && cmd_ok);

	// Word selection from the frozen snapshot; unnamed words read zero
	always_comb begin
		word_nxt = 16'h0000;
		if (!hdr_r) begin
			if (idx_r == `WORD_ECHO) begin
				word_nxt = `STATUS_CMD_CODE;
			end else if (idx_r == `WORD_FLAGS) begin
				word_nxt = {8'h00, snap_r.flags};
			end else if (idx_r == `WORD_STATE) begin
				word_nxt = {8'h00, snap_r.state_code};
			end else if (idx_r == `WORD_ERROR) begin
				word_nxt = {snap_r.err_event, snap_r.err_addr};
			end
		end else begin
			if (idx_r == `HDR_WORD_FLAGS_STATE) begin
				word_nxt = {snap_r.state_code, snap_r.flags};
			end else if (idx_r == `HDR_WORD_EVENT) begin
				word_nxt = {snap_r.err_event, 8'h00};
			end else if (idx_r == `HDR_WORD_BUS_ERRORS) begin
				word_nxt = snap_r.bus_errors;
			end else if (idx_r == `HDR_WORD_TIMEOUTS) begin
				word_nxt = snap_r.timeouts;
			end
		end
	end

	// Accept, snapshot, then one word per cycle through word 9
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			busy_r <= 1'b0;
			hdr_r  <= 1'b0;
			idx_r  <= 4'h0;
			snap_r <= '0;
		end else if (req_take) begin
			busy_r <= 1'b1;
			hdr_r  <= STAT_HEADER;
			idx_r  <= `WORD_ECHO;
			snap_r <= live;
		end else if (busy_r) begin
			busy_r <= idx_r != `REPLY_LAST_WORD;
			idx_r  <= idx_r + 4'h1;
		end
	end

	// Registered reply outputs
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			out_valid_r <= 1'b0;
			out_num_r   <= 4'h0;
			out_data_r  <= 16'h0000;
			refused_r   <= 1'b0;
		end else begin
			out_valid_r <= busy_r;
			out_num_r   <= busy_r ? idx_r : 4'h0;
			out_data_r  <= busy_r ? word_nxt : 16'h0000;
			refused_r   <= req_bad;
		end
	end

	assign STAT_BUSY     = busy_r;
	assign REPLY_VALID   = out_valid_r;
	assign REPLY_NUM     = out_num_r;
	assign REPLY_DATA    = out_data_r;
	assign REPLY_REFUSED = refused_r;

	sequence master_req_seq;
		STAT_REQ && !busy_r && !STAT_HEADER && STAT_CMD == `STATUS_CMD_CODE && size_ok;
	endsequence

	chk_echo_first: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		master_req_seq |-> ##2 REPLY_VALID && REPLY_NUM == 4'h1 && REPLY_DATA == `STATUS_CMD_CODE)
		else $error("first reply word is not the command echo");

	chk_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		master_req_seq |-> ##6 REPLY_NUM == 4'h5 && REPLY_DATA == 16'h0000
		##1 REPLY_DATA == 16'h0000 [*4])
		else $error("reserved reply words not zero");

	// The snapshot holds the record as sampled at the taking edge, five edges back
	chk_error_word: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		master_req_seq ##1 !ERR_VALID |-> ##4 REPLY_DATA == {$past(err_event_r, 5), $past(err_addr_r, 5)})
		else $error("reply word 4 does not hold address and event");

	chk_small_refused: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		STAT_REQ && !busy_r && !size_ok |=> REPLY_REFUSED && !STAT_BUSY ##1 !REPLY_VALID)
		else $error("undersized answer area was not refused");

	chk_hdr_mirror: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
		STAT_REQ && !busy_r && STAT_HEADER && size_ok |-> ##5
		REPLY_DATA == {snap_r.state_code, snap_r.flags} ##1 REPLY_DATA[15:8] == snap_r.err_event)
		else $error("header words 4 and 5 do not mirror status");

endmodule // master_status_reply_builder

`default_nettype wire

// ==== master_status_reply_builder_test.sv ====
// Self-checking bench for the master status reply builder
`timescale 1ns/10ps
`default_nettype none
`include "status_reply_map.svh"

module master_status_reply_builder_test;
	logic clk_sys = 1'b0, reset_n = 1'b0;
	logic param_error = 1'b0, auto_clear_end = 1'b0, no_exchange = 1'b0, fatal_net = 1'b0;
	logic short_event = 1'b0, host_unready = 1'b0, timeout_event = 1'b0, clear_errors = 1'b0;
	logic err_valid = 1'b0, err_from_master = 1'b0, state_go = 1'b0, stat_req = 1'b0, stat_header = 1'b0;
	logic [7:0] err_station = 8'h00, err_code = 8'h00;
	logic [1:0] state_target = 2'h0;
	logic [15:0] stat_cmd = 16'h0000, stat_size = 16'h0000;
	logic stat_busy, reply_valid, reply_refused, load_bus_params, init_diag;
	logic config_slaves, read_inputs, hold_outputs, send_outputs;
	logic [3:0] reply_num;
	logic [15:0] reply_data;
	logic [7:0] control_state_code;
	// Expected model of the reply contents
	logic [7:0] e_state = 8'h00, e_addr = 8'h00, e_ev = 8'h00;
	logic [15:0] e_be = 16'h0000, e_to = 16'h0000;
	logic e_short = 1'b0, e_timeout = 1'b0;
	logic [19:0] exp_q[$];
	logic [19:0] exp_w;
	logic [31:0] r = 32'h1b13260c;
	int mismatches = 0, comparisons = 0;

	master_status_reply_builder i_master_status_reply_builder (
		.CLK_SYS(clk_sys), .RESET_N(reset_n), .PARAM_ERROR(param_error), .AUTO_CLEAR_END(auto_clear_end),
		.NO_EXCHANGE(no_exchange), .FATAL_NET(fatal_net), .SHORT_EVENT(short_event),
		.HOST_UNREADY(host_unready), .TIMEOUT_EVENT(timeout_event), .CLEAR_ERRORS(clear_errors),
		.ERR_VALID(err_valid), .ERR_FROM_MASTER(err_from_master), .ERR_STATION(err_station),
		.ERR_CODE(err_code), .STATE_GO(state_go), .STATE_TARGET(state_target), .STAT_REQ(stat_req),
		.STAT_HEADER(stat_header), .STAT_CMD(stat_cmd), .STAT_SIZE(stat_size), .STAT_BUSY(stat_busy),
		.REPLY_VALID(reply_valid), .REPLY_NUM(reply_num), .REPLY_DATA(reply_data),
		.REPLY_REFUSED(reply_refused), .CONTROL_STATE_CODE(control_state_code),
		.LOAD_BUS_PARAMS(load_bus_params), .INIT_DIAG(init_diag), .CONFIG_SLAVES(config_slaves),
		.READ_INPUTS(read_inputs), .HOLD_OUTPUTS(hold_outputs), .SEND_OUTPUTS(send_outputs));

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	// Checking and closing
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction

	// Expected reply word n of either reply kind
	function automatic logic [15:0] word(input logic hdr, input int n, input logic [7:0] f);
		if (!hdr) begin
			case (n)
				1: return `STATUS_CMD_CODE;
				2: return {8'h00, f};
				3: return {8'h00, e_state};
				4: return {e_ev, e_addr};
				default: return 16'h0000;
			endcase
		end
		case (n)
			4: return {e_state, f};
			5: return {e_ev, 8'h00};
			6: return e_be;
			7: return e_to;
			default: return 16'h0000;
		endcase
	endfunction

	// Monitor: every streamed word is matched against the oldest note
	always @(negedge clk_sys) begin
		if (reply_valid === 1'b1) begin
			if (exp_q.size() == 0) check("unexpected reply word", 32'h1, 32'h0);
			else begin
				exp_w = exp_q.pop_front();
				check("reply word", {reply_num, reply_data}, exp_w);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drivers; flags are sampled into the reply one cycle after the inputs
	task automatic settle;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic request(input logic hdr, input logic [15:0] cmd, input logic [15:0] size, input logic ok);
		int n;
		logic [7:0] f;
		f = {1'b0, e_timeout, host_unready, e_short, fatal_net, no_exchange, auto_clear_end, param_error};
		@(posedge clk_sys);
		stat_req <= 1'b1;
		stat_header <= hdr;
		stat_cmd <= cmd;
		stat_size <= size;
		for (n = 1; n <= 9; n++) if (ok) exp_q.push_back({n[3:0], word(hdr, n, f)});
		@(posedge clk_sys);
		stat_req <= 1'b0;
		@(negedge clk_sys);
		check("refused pulse", reply_refused, !ok);
		check("busy", stat_busy, ok);
		n = 0;
		while (stat_busy !== 1'b0) begin
			n++;
			if (n > 15) begin
				check("busy timeout", 32'h1, 32'h0);
				test_done();
			end
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
		check("words left", exp_q.size(), 0);
	endtask

	// Event pulses; sticky bits and counters follow in the model
	task automatic pulse(input logic sh, input logic to, input logic clr);
		@(posedge clk_sys);
		short_event <= sh;
		timeout_event <= to;
		clear_errors <= clr;
		@(posedge clk_sys);
		short_event <= 1'b0;
		timeout_event <= 1'b0;
		clear_errors <= 1'b0;
		if (clr) {e_short, e_timeout, e_addr, e_ev} = 18'h0;
		if (sh) {e_short, e_be} = {1'b1, e_be + 16'h0001};
		if (to) {e_timeout, e_to} = {1'b1, e_to + 16'h0001};
	endtask

	task automatic err_rep(input logic mst, input logic [7:0] st, input logic [7:0] code);
		@(posedge clk_sys);
		{err_valid, err_from_master, err_station, err_code} <= {1'b1, mst, st, code};
		@(posedge clk_sys);
		err_valid <= 1'b0;
		if (mst) {e_addr, e_ev} = {`MASTER_SOURCE_ADDR, code};
		else if (st <= `MAX_STATION_ADDR) {e_addr, e_ev} = {st, code};
	endtask

	// State change and the duties decoded from it
	task automatic go(input logic [1:0] t);
		logic [4:0] d;
		logic first;
		first = (t == 2'h1) && (e_state != `CODE_HALTED);
		@(posedge clk_sys);
		{state_go, state_target} <= {1'b1, t};
		@(posedge clk_sys);
		state_go <= 1'b0;
		e_state = {t, 6'h00};
		@(negedge clk_sys);
		check("state code", control_state_code, e_state);
		case (e_state)
			`CODE_HALTED: d = 5'h10;
			`CODE_CLEARING: d = 5'h0e;
			`CODE_OPERATING: d = 5'h05;
			default: d = 5'h00;
		endcase
		check("duties", {load_bus_params, config_slaves, read_inputs, hold_outputs, send_outputs}, d);
		check("diag init", init_diag, first);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(negedge clk_sys);
		check("reset state", control_state_code, `CODE_IDLE);
		request(1'b0, `STATUS_CMD_CODE, `REPLY_MIN_WORDS, 1'b1);
		request(1'b1, 16'h0000, `REPLY_MIN_WORDS, 1'b1);
		request(1'b0, 16'h0003, 16'h0009, 1'b0);
		request(1'b1, 16'h0000, 16'h0008, 1'b0);
		request(1'b0, `STATUS_CMD_CODE, 16'h0008, 1'b0);
		go(2'h1);
		go(2'h2);
		go(2'h3);
		go(2'h0);
		// Sticky bits cleared while every level flag is low: whole word zero
		pulse(1'b1, 1'b1, 1'b0);
		pulse(1'b0, 1'b0, 1'b1);
		settle();
		request(1'b1, 16'h0000, 16'h0009, 1'b1);
		// Random level flags and request shapes
		repeat (4) begin
			r = lfsr(r);
			@(posedge clk_sys);
			param_error <= r[0];
			no_exchange <= r[2];
			host_unready <= r[5];
			settle();
			request(r[8], r[8] ? r[31:16] : `STATUS_CMD_CODE, 16'h0009 + r[11:9], 1'b1);
		end
		// Repeated events: bits set once, every one counted
		pulse(1'b1, 1'b0, 1'b0);
		pulse(1'b1, 1'b1, 1'b0);
		pulse(1'b0, 1'b1, 1'b0);
		settle();
		request(1'b1, 16'h0000, 16'h0009, 1'b1);
		// Clear together with a short: the new event wins
		pulse(1'b1, 1'b0, 1'b1);
		settle();
		request(1'b0, `STATUS_CMD_CODE, 16'h0009, 1'b1);
		// Error record from the master, from a station, and an illegal station
		err_rep(1'b1, 8'h10, 8'h32);
		settle();
		request(1'b0, `STATUS_CMD_CODE, 16'h0009, 1'b1);
		err_rep(1'b0, 8'h7d, 8'h11);
		settle();
		request(1'b1, 16'h0000, 16'h0009, 1'b1);
		err_rep(1'b0, 8'h7e, 8'h09);
		settle();
		request(1'b0, `STATUS_CMD_CODE, 16'h0009, 1'b1);
		// Fatal fault and auto-clear end out of operating
		go(2'h3);
		@(posedge clk_sys);
		fatal_net <= 1'b1;
		e_state = `CODE_HALTED;
		settle();
		@(negedge clk_sys);
		check("fatal state", control_state_code, `CODE_HALTED);
		request(1'b1, 16'h0000, 16'h0009, 1'b1);
		@(posedge clk_sys);
		fatal_net <= 1'b0;
		go(2'h3);
		@(posedge clk_sys);
		auto_clear_end <= 1'b1;
		e_state = `CODE_CLEARING;
		settle();
		request(1'b0, `STATUS_CMD_CODE, 16'h0009, 1'b1);
		@(posedge clk_sys);
		auto_clear_end <= 1'b0;
		test_done();
	end
endmodule // master_status_reply_builder_test
`default_nettype wire

// ==== status_reply_map.svh ====
// Offsets, field positions, codes and reset values of the master status reply
`ifndef STATUS_REPLY_MAP_SVH
`define STATUS_REPLY_MAP_SVH

`define STATUS_CMD_CODE       16'h0002
`define REPLY_MIN_WORDS       16'h0009
`define REPLY_LAST_WORD       4'h9
`define WORD_ECHO             4'h1
`define WORD_FLAGS            4'h2
`define WORD_STATE            4'h3
`define WORD_ERROR            4'h4
`define HDR_WORD_FLAGS_STATE  4'h4
`define HDR_WORD_EVENT        4'h5
`define HDR_WORD_BUS_ERRORS   4'h6
`define HDR_WORD_TIMEOUTS     4'h7

`define FLAG_PARAM_BIT        0
`define FLAG_AUTO_CLEAR_BIT   1
`define FLAG_NO_EXCHANGE_BIT  2
`define FLAG_FATAL_BIT        3
`define FLAG_SHORT_BIT        4
`define FLAG_UNREADY_BIT      5
`define FLAG_TIMEOUT_BIT      6

`define CODE_IDLE             8'h00
`define CODE_HALTED           8'h40
`define CODE_CLEARING         8'h80
`define CODE_OPERATING        8'hc0

`define MASTER_SOURCE_ADDR    8'hff
`define MAX_STATION_ADDR      8'h7d
`define NO_ERROR_ADDR         8'h00
`define NO_ERROR_EVENT        8'h00
`define FLAGS_RESET           8'h00
`define COUNT_RESET           16'h0000

`endif

// ==== status_reply_pkg.sv ====
// Types shared by the master status reply builder
package status_reply_pkg;

	// Control states, encoded as the reported state code
	typedef enum logic [7:0] {
		IDLE_STATE = 8'h00,
		HALTED     = 8'h40,
		CLEARING   = 8'h80,
		OPERATING  = 8'hc0
	} ctrl_state_type;

	// Global state flag byte
	typedef struct packed {
		logic reserved7;
		logic telegram_timeout_flag;
		logic host_unready_flag;
		logic short_circuit_flag;
		logic fatal_net_flag;
		logic no_exchange_flag;
		logic auto_clear_flag;
		logic param_error_flag;
	} flags_type;

	// Everything a reply is built from, captured together
	typedef struct packed {
		flags_type   flags;
		logic [7:0]  state_code;
		logic [7:0]  err_addr;
		logic [7:0]  err_event;
		logic [15:0] bus_errors;
		logic [15:0] timeouts;
	} snapshot_type;

endpackage
